/* hw/ebrf_regs.svh */
// Constants and register map of the block RAM FIFO
`ifndef EBRF_REGS_SVH
`define EBRF_REGS_SVH

`define EBRF_DW       18
`define EBRF_LW       9
`define EBRF_LANES    2
`define EBRF_AW       9
`define EBRF_PW       10
`define EBRF_DEPTH    512
`define EBRF_ONE      10'h001
`define EBRF_TH_ONE   9'h001
`define EBRF_CS_ON    3'h4
`define EBRF_CS_OFF   3'h0

`define EBRF_FULL_RST 9'h1FF
`define EBRF_AF_RST   9'h1F0
`define EBRF_AE_RST   9'h010
`define EBRF_CW       10
`define EBRF_CTRL_RST 10'h301

`define EBRF_C_FIFO   0
`define EBRF_C_WM     2:1
`define EBRF_C_ASYNC  3
`define EBRF_C_CLR    4
`define EBRF_C_RWD    5
`define EBRF_C_LRA    6
`define EBRF_C_LRB    7
`define EBRF_C_LANE   9:8

`define EBRF_AVW      3
`define EBRF_BW       32
`define EBRF_A_CTRL   3'h0
`define EBRF_A_FULL   3'h1
`define EBRF_A_AF     3'h2
`define EBRF_A_AE     3'h3
`define EBRF_A_STAT   3'h4
`define EBRF_A_DATA   3'h5
`define EBRF_A_ADDR   3'h6
`define EBRF_A_AOUT   3'h7

`endif

/* hw/ebrf_pkg.sv */
// Types of the block RAM FIFO: write modes for both ends, states of the fabric end
package ebrf_pkg;
  typedef enum logic [1:0] {
    ebrf_wm_normal,
    ebrf_wm_through,
    ebrf_wm_rbw
  } ebrf_wmode_t;

  typedef enum logic [2:0] {
    ebrf_st_idle,
    ebrf_st_access,
    ebrf_st_fetch,
    ebrf_st_answer,
    ebrf_st_quiet,
    ebrf_st_hit,
    ebrf_st_release
  } ebrf_state_t;
endpackage

/* hw/ebrf_if.sv */
// Signals between the fabric user end and the memory end
`timescale 1ns/10ps
`default_nettype none
`include "ebrf_regs.svh"
interface ebrf_if
  import ebrf_pkg::*;
();
  logic [`EBRF_DW-1:0]    wr_data;
  logic [`EBRF_LANES-1:0] lane_mask;
  logic                   write_clock_enable;
  logic                   write_enable;
  logic [1:0]             write_port_select;
  logic                   full_in;
  logic                   read_clock_enable;
  logic                   read_enable;
  logic [1:0]             read_port_select;
  logic                   empty_in;
  logic [`EBRF_AW-1:0]    ram_addr;
  logic                   fifo_mode;
  ebrf_wmode_t            write_mode;
  logic                   latch_async;
  logic                   port_a_latch_reset;
  logic                   port_b_latch_reset;
  logic                   global_clear;
  logic                   read_pointer_rewind;
  logic [`EBRF_AW-1:0]    full_threshold;
  logic [`EBRF_AW-1:0]    almost_full_threshold;
  logic [`EBRF_AW-1:0]    almost_empty_threshold;
  logic [`EBRF_DW-1:0]    rd_data;
  logic [`EBRF_DW-1:0]    port_a_data;
  logic                   full_flag;
  logic                   almost_full_flag;
  logic                   empty_flag;
  logic                   almost_empty_flag;

  modport dev (
    input  wr_data, lane_mask, write_clock_enable, write_enable, write_port_select,
    input  full_in, read_clock_enable, read_enable, read_port_select, empty_in,
    input  ram_addr, fifo_mode, write_mode, latch_async, port_a_latch_reset,
    input  port_b_latch_reset, global_clear, read_pointer_rewind, full_threshold,
    input  almost_full_threshold, almost_empty_threshold,
    output rd_data, port_a_data, full_flag, almost_full_flag, empty_flag,
    output almost_empty_flag
  );

  modport usr (
    output wr_data, lane_mask, write_clock_enable, write_enable, write_port_select,
    output full_in, read_clock_enable, read_enable, read_port_select, empty_in,
    output ram_addr, fifo_mode, write_mode, latch_async, port_a_latch_reset,
    output port_b_latch_reset, global_clear, read_pointer_rewind, full_threshold,
    output almost_full_threshold, almost_empty_threshold,
    input  rd_data, port_a_data, full_flag, almost_full_flag, empty_flag,
    input  almost_empty_flag
  );
endinterface
`default_nettype wire

/* hw/ebrf_port.sv */
// Output latch of one memory port with write behaviour and resets
`timescale 1ns/10ps
`default_nettype none
`include "ebrf_regs.svh"
module ebrf_port
  import ebrf_pkg::*;
(
  input  wire logic                clk_in,
  input  wire logic                nrst_in,
  input  wire logic                ce_in,
  input  wire logic                acc_in,
  input  wire logic                we_in,
  input  wire ebrf_wmode_t         mode_in,
  input  wire logic                async_in,
  input  wire logic                lrst_in,
  input  wire logic [`EBRF_DW-1:0] din_in,
  input  wire logic [`EBRF_DW-1:0] old_in,
  output var  logic [`EBRF_DW-1:0] dout_out
);
  logic latch_rst_n;

  // local async reset joins device-wide reset
  assign latch_rst_n = nrst_in & ~(async_in & lrst_in);

  always_ff @(posedge clk_in or negedge latch_rst_n) begin
    if (!latch_rst_n) begin
      dout_out <= '0;
    end else if (ce_in) begin
      if (!async_in && lrst_in) begin
        dout_out <= '0;
      end else if (acc_in && !we_in) begin
        dout_out <= old_in;
      end else if (acc_in) begin
        case (mode_in)
          ebrf_wm_through: dout_out <= din_in;
          ebrf_wm_rbw:     dout_out <= old_in;
          default:         dout_out <= dout_out;
        endcase
      end
    end
  end
endmodule
`default_nettype wire

/* hw/ebrf_device.sv */
// Memory end: block RAM array, port latches, FIFO pointers and flags
//
// The implementer's own choices: the Avalon-MM interface to the registers and the address map.
`timescale 1ns/10ps
`default_nettype none
`include "ebrf_regs.svh"
module ebrf_device
  import ebrf_pkg::*;
(
  input  wire logic clk_in,
  input  wire logic nrst_in,
  input  wire logic ce_in,
  ebrf_if.dev       fab
);
  // never preloaded, so device-wide reset stays on
  logic [`EBRF_DW-1:0] mem [`EBRF_DEPTH];

  logic [`EBRF_PW-1:0] wptr;
  logic [`EBRF_PW-1:0] rptr;
  logic [`EBRF_PW-1:0] next_wptr;
  logic [`EBRF_PW-1:0] next_rptr;
  logic [`EBRF_PW-1:0] level;
  logic [`EBRF_AW-1:0] full_th;
  logic [`EBRF_AW-1:0] af_th;
  logic [`EBRF_AW-1:0] ae_th;
  logic                fifo_rst_n;
  logic                rd_rst_n;
  logic                wr_sel;
  logic                rd_sel;
  logic                push;
  logic                pop;
  logic                a_acc;
  logic                a_we;
  logic                b_acc;
  logic [`EBRF_AW-1:0] a_addr;
  logic [`EBRF_AW-1:0] b_addr;
  logic [`EBRF_DW-1:0] a_old;
  logic [`EBRF_DW-1:0] b_old;
  logic [`EBRF_DW-1:0] a_merged;

  function automatic logic selected(input logic top, input logic [1:0] low);
    return {top, low} == `EBRF_CS_ON;
  endfunction

  function automatic logic [`EBRF_PW-1:0] fill(input logic [`EBRF_PW-1:0] w,
                                               input logic [`EBRF_PW-1:0] r);
    return w - r;
  endfunction

  function automatic logic at_least(input logic [`EBRF_PW-1:0] lvl,
                                    input logic [`EBRF_AW-1:0] th);
    return lvl >= {1'b0, th};
  endfunction

  // Keeps a threshold inside 1 .. limit
  function automatic logic [`EBRF_AW-1:0] clamp(input logic [`EBRF_AW-1:0] th,
                                                input logic [`EBRF_AW-1:0] limit);
    logic [`EBRF_AW-1:0] res;
    res = th;
    if (th == '0) begin
      res = `EBRF_TH_ONE;
    end else if (th > limit) begin
      res = limit;
    end
    return res;
  endfunction

  // full threshold within 1 .. 2^N-1
  assign full_th = clamp(fab.full_threshold, '1);

  // almost thresholds within 1 .. full-1
  assign af_th = clamp(fab.almost_full_threshold, full_th - `EBRF_TH_ONE);
  assign ae_th = clamp(fab.almost_empty_threshold, full_th - `EBRF_TH_ONE);

  // select bit 2 from full/empty in
  assign wr_sel = selected(fab.full_in, fab.write_port_select);
  assign rd_sel = selected(fab.empty_in, fab.read_port_select);

  assign push = fab.fifo_mode & fab.write_clock_enable & fab.write_enable
                & wr_sel & ~fab.full_flag;

  assign pop = fab.fifo_mode & fab.read_clock_enable & fab.read_enable
               & rd_sel & ~fab.empty_flag;

  // Port A writes (and reads in RAM mode), port B reads; RAM mode shares one address
  assign a_acc  = fab.fifo_mode ? push : (fab.write_clock_enable & wr_sel);
  assign a_we   = fab.fifo_mode ? push : fab.write_enable;
  assign a_addr = fab.fifo_mode ? wptr[`EBRF_AW-1:0] : fab.ram_addr;
  assign b_acc  = fab.fifo_mode ? pop : (fab.read_clock_enable & rd_sel);
  assign b_addr = fab.fifo_mode ? rptr[`EBRF_AW-1:0] : fab.ram_addr;
  assign a_old  = mem[a_addr];
  assign b_old  = mem[b_addr];

  // Lane mask only applies outside FIFO mode
  always_comb begin
    a_merged = a_old;
    for (int i = 0; i < `EBRF_LANES; i++) begin
      if (fab.fifo_mode || fab.lane_mask[i]) begin
        a_merged[i*`EBRF_LW +: `EBRF_LW] = fab.wr_data[i*`EBRF_LW +: `EBRF_LW];
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (ce_in && a_acc && a_we) begin
      mem[a_addr] <= a_merged;
    end
  end

  ebrf_port u_port_a (
    .clk_in   (clk_in),
    .nrst_in  (nrst_in),
    .ce_in    (ce_in),
    .acc_in   (a_acc),
    .we_in    (a_we),
    .mode_in  (fab.write_mode),
    .async_in (fab.latch_async),
    .lrst_in  (fab.port_a_latch_reset),
    .din_in   (fab.wr_data),
    .old_in   (a_old),
    .dout_out (fab.port_a_data)
  );

  ebrf_port u_port_b (
    .clk_in   (clk_in),
    .nrst_in  (nrst_in),
    .ce_in    (ce_in),
    .acc_in   (b_acc),
    .we_in    (1'b0),
    .mode_in  (ebrf_wm_normal),
    .async_in (fab.latch_async),
    .lrst_in  (fab.port_b_latch_reset),
    .din_in   (fab.wr_data),
    .old_in   (b_old),
    .dout_out (fab.rd_data)
  );

  // clear empties both pointers at once
  assign fifo_rst_n = nrst_in & ~fab.global_clear;

  // rewind touches the read pointer only
  assign rd_rst_n = fifo_rst_n & ~fab.read_pointer_rewind;

  assign next_wptr = push ? wptr + `EBRF_ONE : wptr;
  assign next_rptr = pop ? rptr + `EBRF_ONE : rptr;

  always_ff @(posedge clk_in or negedge fifo_rst_n) begin
    if (!fifo_rst_n) begin
      wptr <= '0;
    end else if (ce_in) begin
      wptr <= next_wptr;
    end
  end

  // Rewind replays only while the writer has not wrapped
  always_ff @(posedge clk_in or negedge rd_rst_n) begin
    if (!rd_rst_n) begin
      rptr <= '0;
    end else if (ce_in) begin
      rptr <= next_rptr;
    end
  end

  assign level = fill(next_wptr, next_rptr);

  always_ff @(posedge clk_in or negedge fifo_rst_n) begin
    if (!fifo_rst_n) begin
      fab.full_flag        <= 1'b0;
      fab.almost_full_flag <= 1'b0;
    end else if (ce_in) begin
      fab.full_flag        <= at_least(level, full_th);
      fab.almost_full_flag <= at_least(level, af_th);
    end
  end

  always_ff @(posedge clk_in or negedge fifo_rst_n) begin
    if (!fifo_rst_n) begin
      fab.empty_flag        <= 1'b1;
      fab.almost_empty_flag <= 1'b1;
    end else if (ce_in) begin
      fab.empty_flag        <= (level == '0);
      fab.almost_empty_flag <= ~at_least(level, ae_th + `EBRF_TH_ONE);
    end
  end
endmodule
`default_nettype wire

/* hw/ebrf_user.sv */
// Fabric end: Avalon-MM registers driving the memory and reset sequence
`timescale 1ns/10ps
`default_nettype none
`include "ebrf_regs.svh"
module ebrf_user
  import ebrf_pkg::*;
(
  input  wire logic                 clk_in,
  input  wire logic                 nrst_in,
  input  wire logic                 ce_in,
  input  wire logic [`EBRF_AVW-1:0] avs_address,
  input  wire logic                 avs_read,
  input  wire logic                 avs_write,
  input  wire logic [`EBRF_BW-1:0]  avs_writedata,
  output var  logic [`EBRF_BW-1:0]  avs_readdata,
  output var  logic                 avs_waitrequest,
  ebrf_if.usr                       fab
);
  ebrf_state_t         state;
  ebrf_state_t         next_state;
  logic [`EBRF_CW-1:0] ctrl;
  logic [3:0]          pend;
  logic                req;
  logic                is_data;
  logic                quiet;
  logic                pulse_req;

  assign req     = avs_read | avs_write;
  assign is_data = avs_address == `EBRF_A_DATA;
  assign quiet   = next_state inside {ebrf_st_quiet, ebrf_st_hit, ebrf_st_release};

  // Control write asking for a pulse enters the sequence at once
  assign pulse_req = avs_write && avs_address == `EBRF_A_CTRL
                     && avs_writedata[`EBRF_C_LRB:`EBRF_C_CLR] != '0;

  function automatic logic [`EBRF_BW-1:0] reg_mux(input logic [`EBRF_AVW-1:0] a);
    logic [`EBRF_BW-1:0] v;
    v = '0;
    case (a)
      `EBRF_A_CTRL: v = `EBRF_BW'(ctrl);
      `EBRF_A_FULL: v = `EBRF_BW'(fab.full_threshold);
      `EBRF_A_AF:   v = `EBRF_BW'(fab.almost_full_threshold);
      `EBRF_A_AE:   v = `EBRF_BW'(fab.almost_empty_threshold);
      `EBRF_A_STAT: v = `EBRF_BW'({fab.full_flag, fab.almost_full_flag,
                                   fab.almost_empty_flag, fab.empty_flag});
      `EBRF_A_ADDR: v = `EBRF_BW'(fab.ram_addr);
      `EBRF_A_AOUT: v = `EBRF_BW'(fab.port_a_data);
      default:      v = '0;
    endcase
    return v;
  endfunction

  always_comb begin
    next_state = state;
    case (state)
      ebrf_st_idle:    if (req) next_state = is_data ? ebrf_st_access : ebrf_st_answer;
      ebrf_st_access:  next_state = avs_read ? ebrf_st_fetch : ebrf_st_answer;
      ebrf_st_fetch:   next_state = ebrf_st_answer;
      ebrf_st_answer:  next_state = (pend != '0 || pulse_req) ? ebrf_st_quiet : ebrf_st_idle;
      // enables low before and after reset
      ebrf_st_quiet:   next_state = ebrf_st_hit;
      ebrf_st_hit:     next_state = ebrf_st_release;
      ebrf_st_release: next_state = ebrf_st_idle;
      default:         next_state = ebrf_st_idle;
    endcase
  end

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      state           <= ebrf_st_idle;
      avs_waitrequest <= 1'b1;
    end else if (ce_in) begin
      state           <= next_state;
      avs_waitrequest <= next_state != ebrf_st_answer;
    end
  end

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      avs_readdata <= '0;
    end else if (ce_in) begin
      if (state == ebrf_st_idle && req && !is_data) begin
        avs_readdata <= reg_mux(avs_address);
      end else if (state == ebrf_st_fetch) begin
        avs_readdata <= `EBRF_BW'(fab.fifo_mode ? fab.rd_data : fab.port_a_data);
      end
    end
  end

  // Register writes take effect on the answer edge
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      ctrl                       <= `EBRF_CTRL_RST;
      pend                       <= '0;
      fab.full_threshold         <= `EBRF_FULL_RST;
      fab.almost_full_threshold  <= `EBRF_AF_RST;
      fab.almost_empty_threshold <= `EBRF_AE_RST;
      fab.ram_addr               <= '0;
    end else if (ce_in) begin
      if (state == ebrf_st_answer && avs_write) begin
        case (avs_address)
          `EBRF_A_CTRL: begin
            ctrl <= avs_writedata[`EBRF_CW-1:0] & ~`EBRF_CW'(8'hF0);
            pend <= avs_writedata[`EBRF_C_LRB:`EBRF_C_CLR];
          end
          `EBRF_A_FULL: fab.full_threshold         <= avs_writedata[`EBRF_AW-1:0];
          `EBRF_A_AF:   fab.almost_full_threshold  <= avs_writedata[`EBRF_AW-1:0];
          `EBRF_A_AE:   fab.almost_empty_threshold <= avs_writedata[`EBRF_AW-1:0];
          `EBRF_A_ADDR: fab.ram_addr               <= avs_writedata[`EBRF_AW-1:0];
          default:      ctrl                       <= ctrl;
        endcase
      end else if (state == ebrf_st_release) begin
        pend <= '0;
      end
    end
  end

  assign fab.fifo_mode   = ctrl[`EBRF_C_FIFO];
  assign fab.write_mode  = ebrf_wmode_t'(ctrl[`EBRF_C_WM]);
  assign fab.latch_async = ctrl[`EBRF_C_ASYNC];
  assign fab.lane_mask   = ctrl[`EBRF_C_LANE];

  // Access strobes, enables and reset pulses
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      fab.write_clock_enable  <= 1'b0;
      fab.read_clock_enable   <= 1'b0;
      fab.write_enable        <= 1'b0;
      fab.read_enable         <= 1'b0;
      {fab.full_in, fab.write_port_select} <= `EBRF_CS_OFF;
      {fab.empty_in, fab.read_port_select} <= `EBRF_CS_OFF;
      fab.wr_data             <= '0;
      fab.global_clear        <= 1'b0;
      fab.read_pointer_rewind <= 1'b0;
      fab.port_a_latch_reset  <= 1'b0;
      fab.port_b_latch_reset  <= 1'b0;
    end else if (ce_in) begin
      fab.write_clock_enable <= !quiet;
      fab.read_clock_enable  <= !quiet;
      fab.write_enable <= next_state == ebrf_st_access && avs_write;
      fab.read_enable  <= next_state == ebrf_st_access && avs_read;
      // chip select with bit 2 on full/empty in
      {fab.full_in, fab.write_port_select} <=
        (next_state == ebrf_st_access && (avs_write || !fab.fifo_mode))
        ? `EBRF_CS_ON : `EBRF_CS_OFF;
      {fab.empty_in, fab.read_port_select} <=
        (next_state == ebrf_st_access && avs_read && fab.fifo_mode)
        ? `EBRF_CS_ON : `EBRF_CS_OFF;
      if (state == ebrf_st_idle && req) begin
        fab.wr_data <= avs_writedata[`EBRF_DW-1:0];
      end
      // pulses from flops, only while enables are low
      fab.global_clear        <= next_state == ebrf_st_hit && pend[0];
      fab.read_pointer_rewind <= next_state == ebrf_st_hit && pend[1];
      fab.port_a_latch_reset  <= next_state == ebrf_st_hit && pend[2];
      fab.port_b_latch_reset  <= next_state == ebrf_st_hit && pend[3];
    end
  end
endmodule
`default_nettype wire

/* verif/ebrf_sva.sv */
// Assertions on the link between the fabric end and the memory end
`timescale 1ns/10ps
`default_nettype none
`include "ebrf_regs.svh"
module ebrf_sva
  import ebrf_pkg::*;
(
  input wire logic                   clk_in,
  input wire logic                   nrst_in,
  input wire logic [`EBRF_DW-1:0]    wr_data,
  input wire logic [`EBRF_LANES-1:0] lane_mask,
  input wire logic                   write_clock_enable,
  input wire logic                   write_enable,
  input wire logic [1:0]             write_port_select,
  input wire logic                   full_in,
  input wire logic                   read_clock_enable,
  input wire logic                   read_enable,
  input wire logic                   fifo_mode,
  input wire ebrf_wmode_t            write_mode,
  input wire logic                   port_a_latch_reset,
  input wire logic                   port_b_latch_reset,
  input wire logic                   global_clear,
  input wire logic                   read_pointer_rewind,
  input wire logic [`EBRF_DW-1:0]    rd_data,
  input wire logic [`EBRF_DW-1:0]    port_a_data,
  input wire logic                   full_flag,
  input wire logic                   almost_full_flag,
  input wire logic                   empty_flag,
  input wire logic                   almost_empty_flag
);
  logic pulse;
  logic wr_acc;
  assign pulse = global_clear | read_pointer_rewind | port_a_latch_reset | port_b_latch_reset;
  assign wr_acc = !fifo_mode && write_clock_enable && write_enable && full_in &&
                  write_port_select == 2'h0 && lane_mask == 2'h3;
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!nrst_in);
  sequence s_quiet;
    !write_clock_enable && !read_clock_enable;
  endsequence
  sequence s_run;
    write_clock_enable && read_clock_enable;
  endsequence
  a_quiet_before: assert property (
    $rose(pulse) |-> !$past(write_clock_enable) && !$past(read_clock_enable))
    else $error("enables not low before reset pulse");
  a_quiet_after: assert property (
    $rose(pulse) |-> s_quiet ##1 s_quiet ##1 s_run)
    else $error("enable sequence around reset pulse broken");
  a_normal_hold: assert property (
    wr_acc && write_mode == ebrf_wm_normal |=> $stable(port_a_data))
    else $error("normal write changed port A output");
  a_through_copy: assert property (
    wr_acc && write_mode == ebrf_wm_through |=> port_a_data == $past(wr_data))
    else $error("write-through word missing on port A");
  a_clear_flags: assert property (
    global_clear |-> ##2 (empty_flag && almost_empty_flag && !full_flag && !almost_full_flag))
    else $error("flags not back to reset state after clear");
  a_latch_a_clear: assert property (
    port_a_latch_reset |-> ##2 port_a_data == '0)
    else $error("port A latch not cleared");
  a_latch_b_clear: assert property (
    port_b_latch_reset |-> ##2 rd_data == '0)
    else $error("port B latch not cleared");
  a_flag_nest: assert property (
    (empty_flag |-> almost_empty_flag) and (full_flag |-> almost_full_flag))
    else $error("flag thresholds out of order");
  a_full_holds: assert property (
    fifo_mode && write_clock_enable && write_enable && full_flag |=> full_flag)
    else $error("full flag dropped on refused push");
  a_empty_holds: assert property (
    fifo_mode && read_clock_enable && read_enable && empty_flag |=>
    empty_flag && $stable(rd_data))
    else $error("refused pop changed state");
endmodule
`default_nettype wire

/* verif/embedded_block_ram_fifo_tb.sv */
// Bench joining the fabric end and the memory end over the shared interface
`timescale 1ns/10ps
`default_nettype none
`include "ebrf_regs.svh"
module embedded_block_ram_fifo_tb;
  logic                 clk_in = 1'b0;
  logic                 nrst_in = 1'b0;
  logic [`EBRF_AVW-1:0] avs_address = 3'h0;
  logic                 avs_read = 1'b0;
  logic                 avs_write = 1'b0;
  logic [`EBRF_BW-1:0]  avs_writedata = 32'h0;
  logic [`EBRF_BW-1:0]  avs_readdata;
  logic                 avs_waitrequest;
  int                   n_fail = 0;
  int                   n_compared = 0;
  localparam logic [3:0] ST_UP [5] = '{4'h2, 4'h0, 4'h4, 4'hC, 4'hC};
  localparam logic [3:0] ST_DN [4] = '{4'h4, 4'h0, 4'h2, 4'h3};

  always #12.5 clk_in = ~clk_in;

  ebrf_if ebrf_if_inst ();
  ebrf_device ebrf_device_inst (.clk_in(clk_in), .nrst_in(nrst_in), .ce_in(1'b1),
    .fab(ebrf_if_inst.dev));
  ebrf_user ebrf_user_inst (.clk_in(clk_in), .nrst_in(nrst_in), .ce_in(1'b1),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .fab(ebrf_if_inst.usr));
  ebrf_sva ebrf_sva_inst (.clk_in(clk_in), .nrst_in(nrst_in),
    .wr_data(ebrf_if_inst.wr_data), .lane_mask(ebrf_if_inst.lane_mask),
    .write_clock_enable(ebrf_if_inst.write_clock_enable),
    .write_enable(ebrf_if_inst.write_enable),
    .write_port_select(ebrf_if_inst.write_port_select), .full_in(ebrf_if_inst.full_in),
    .read_clock_enable(ebrf_if_inst.read_clock_enable),
    .read_enable(ebrf_if_inst.read_enable), .fifo_mode(ebrf_if_inst.fifo_mode),
    .write_mode(ebrf_if_inst.write_mode),
    .port_a_latch_reset(ebrf_if_inst.port_a_latch_reset),
    .port_b_latch_reset(ebrf_if_inst.port_b_latch_reset),
    .global_clear(ebrf_if_inst.global_clear),
    .read_pointer_rewind(ebrf_if_inst.read_pointer_rewind),
    .rd_data(ebrf_if_inst.rd_data), .port_a_data(ebrf_if_inst.port_a_data),
    .full_flag(ebrf_if_inst.full_flag), .almost_full_flag(ebrf_if_inst.almost_full_flag),
    .empty_flag(ebrf_if_inst.empty_flag),
    .almost_empty_flag(ebrf_if_inst.almost_empty_flag));

  task automatic give_verdict();
    $display("compared %0d mismatched %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
      n_fail++;
    end
  endtask

  // One Avalon cycle, held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [2:0] adr, input logic [31:0] wd,
                     output logic [31:0] rd);
    int n;
    @(posedge clk_in);
    avs_read <= !wr;
    avs_write <= wr;
    avs_address <= adr;
    avs_writedata <= wd;
    n = 0;
    do begin
      @(posedge clk_in);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 100);
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    if (avs_waitrequest !== 1'b0) begin
      n_fail++;
      give_verdict();
    end
  endtask

  task automatic wr(input logic [2:0] adr, input logic [31:0] d);
    logic [31:0] x;
    bus(1'b1, adr, d, x);
  endtask

  task automatic rchk(input logic [2:0] adr, input logic [31:0] exp, input string what);
    logic [31:0] x;
    bus(1'b0, adr, 32'h0, x);
    check(what, exp, x);
  endtask

  task automatic t_defaults();
    rchk(`EBRF_A_CTRL, 32'h301, "ctrl");
    rchk(`EBRF_A_FULL, 32'h1FF, "full th");
    rchk(`EBRF_A_AF, 32'h1F0, "af th");
    rchk(`EBRF_A_AE, 32'h010, "ae th");
    rchk(`EBRF_A_STAT, 32'h3, "status");
  endtask

  task automatic t_fill();
    wr(`EBRF_A_FULL, 32'h4);
    wr(`EBRF_A_AF, 32'h3);
    wr(`EBRF_A_AE, 32'h1);
    for (int i = 0; i < 5; i++) begin
      wr(`EBRF_A_DATA, 32'h2A001 + i);
      rchk(`EBRF_A_STAT, {28'h0, ST_UP[i]}, "status fill");
    end
    for (int i = 0; i < 4; i++) begin
      rchk(`EBRF_A_DATA, 32'h2A001 + i, "pop");
      rchk(`EBRF_A_STAT, {28'h0, ST_DN[i]}, "status drain");
    end
    rchk(`EBRF_A_DATA, 32'h2A004, "stale pop");
  endtask

  task automatic t_rewind();
    wr(`EBRF_A_CTRL, 32'h311);
    wr(`EBRF_A_DATA, 32'h2A011);
    wr(`EBRF_A_DATA, 32'h2A012);
    rchk(`EBRF_A_DATA, 32'h2A011, "pop a");
    rchk(`EBRF_A_DATA, 32'h2A012, "pop b");
    wr(`EBRF_A_CTRL, 32'h321);
    rchk(`EBRF_A_STAT, 32'h0, "status rewind");
    rchk(`EBRF_A_DATA, 32'h2A011, "replay a");
    rchk(`EBRF_A_DATA, 32'h2A012, "replay b");
  endtask

  task automatic t_clear();
    wr(`EBRF_A_DATA, 32'h2A020);
    wr(`EBRF_A_CTRL, 32'h311);
    rchk(`EBRF_A_STAT, 32'h3, "status clear");
    wr(`EBRF_A_DATA, 32'h2A021);
    rchk(`EBRF_A_DATA, 32'h2A021, "pop after clear");
  endtask

  task automatic t_thresh();
    logic [31:0] x;
    wr(`EBRF_A_FULL, 32'h0);
    rchk(`EBRF_A_FULL, 32'h0, "full min");
    bus(1'b0, `EBRF_A_STAT, 32'h0, x);
    check("full floor", 32'h0, x & 32'h8);
    wr(`EBRF_A_FULL, 32'h1FF);
    rchk(`EBRF_A_FULL, 32'h1FF, "full max");
    wr(`EBRF_A_AF, 32'h1FF);
    rchk(`EBRF_A_AF, 32'h1FF, "af max");
    wr(`EBRF_A_AE, 32'h0);
    rchk(`EBRF_A_AE, 32'h0, "ae min");
    wr(`EBRF_A_DATA, 32'h2A030);
    rchk(`EBRF_A_STAT, 32'h2, "ae floor");
    rchk(`EBRF_A_DATA, 32'h2A030, "pop floor");
  endtask

  task automatic t_ram();
    logic [31:0] x;
    wr(`EBRF_A_CTRL, 32'h302);
    wr(`EBRF_A_ADDR, 32'h5);
    wr(`EBRF_A_DATA, 32'h1A5A5);
    rchk(`EBRF_A_AOUT, 32'h1A5A5, "through");
    wr(`EBRF_A_CTRL, 32'h300);
    wr(`EBRF_A_DATA, 32'h05A5A);
    rchk(`EBRF_A_AOUT, 32'h1A5A5, "normal write");
    bus(1'b0, `EBRF_A_DATA, 32'h0, x);
    rchk(`EBRF_A_AOUT, 32'h05A5A, "normal read");
    wr(`EBRF_A_CTRL, 32'h304);
    wr(`EBRF_A_DATA, 32'h3C3C3);
    rchk(`EBRF_A_AOUT, 32'h05A5A, "old word");
    wr(`EBRF_A_CTRL, 32'h344);
    rchk(`EBRF_A_AOUT, 32'h0, "latch a sync");
    bus(1'b0, `EBRF_A_DATA, 32'h0, x);
    rchk(`EBRF_A_AOUT, 32'h3C3C3, "rbw stored");
    wr(`EBRF_A_CTRL, 32'h34C);
    rchk(`EBRF_A_AOUT, 32'h0, "latch a async");
    wr(`EBRF_A_CTRL, 32'h380);
    rchk(`EBRF_A_AOUT, 32'h0, "idle");
    check("latch b", 32'h0, {14'h0, ebrf_if_inst.rd_data});
  endtask

  task automatic t_reset();
    logic [31:0] x;
    bus(1'b0, `EBRF_A_DATA, 32'h0, x);
    wr(`EBRF_A_CTRL, 32'h1);
    wr(`EBRF_A_DATA, 32'h15555);
    rchk(`EBRF_A_DATA, 32'h15555, "pop");
    rchk(`EBRF_A_AOUT, 32'h3C3C3, "a before reset");
    @(posedge clk_in);
    nrst_in <= 1'b0;
    #1;
    check("reset a", 32'h0, {14'h0, ebrf_if_inst.port_a_data});
    check("reset b", 32'h0, {14'h0, ebrf_if_inst.rd_data});
    repeat (4) @(posedge clk_in);
    nrst_in <= 1'b1;
    repeat (2) @(posedge clk_in);
    rchk(`EBRF_A_CTRL, 32'h301, "ctrl again");
  endtask

  initial begin
    repeat (4) @(posedge clk_in);
    nrst_in <= 1'b1;
    repeat (2) @(posedge clk_in);
    t_defaults();
    t_fill();
    t_rewind();
    t_clear();
    t_thresh();
    t_ram();
    t_reset();
    give_verdict();
  end
endmodule
`default_nettype wire
